// [rtl/acd_host_port.sv]
// Serial slave port, ready output and standby/detect mode control
// How it works
// - Hold command stops channels, keeps settings
// - Resume command returns to conversion
// - Sampling restarts after eight master-clock periods
// - Detect mode entered from standby by short pulse
// - Enough hits drop ready, back to standby
// - Detect samples feed comparator only
// - Detect enable input gates detect mode
// - Threshold is 24 bits from two parts
// - Sample-count field picks samples per evaluation
// - Hit-count field sets needed exceedances
// - All-channels bit chooses all or any
// - Only enabled channels join detection
// - Slave in mode 1, full duplex
// - Chip select high ignores clock, output floats
// - Launch on rising, capture on falling edge
// - Ready flags new data or detection
// - Source select picks lagging, any, or leading
// - First ready delayed when phase at boundary
// - Style bit picks push-pull or open drain
// - Level or pulse format, unread skips pulse
// - Conversion during data read suppresses ready
// - Word length 16, 24 or 32 bits
// - First word answers previous frame command
`timescale 1ns/10ps
`include "acd_params.svh"
module acd_host_port
	import acd_pkg::*;
#(
	parameter int P_RESET_LIMIT_CYC = `ACD_RESET_LIMIT_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	input wire logic i_sync_reset_n,
	input wire logic i_master_clock_input,
	input wire logic [1:0] i_word_length_select,
	input wire logic [1:0] i_ready_source_select,
	input wire logic i_ready_open_drain,
	input wire logic i_ready_pulse_format,
	input wire logic i_global_chop,
	input wire logic [2:0] i_oversampling_ratio,
	input wire logic [3:0] i_channel_enable_n,
	input wire logic [3:0][9:0] i_channel_phase_trim,
	input wire logic [15:0] i_status_word,
	input wire logic [3:0] i_conv_done,
	input wire logic [3:0][23:0] i_conv_data,
	input wire logic i_detect_enable,
	input wire logic [15:0] i_detect_level_high_reg,
	input wire logic [7:0] i_detect_level_low_reg,
	input wire logic [2:0] i_detect_sample_count,
	input wire logic [2:0] i_detect_hit_count,
	input wire logic i_detect_all_channels,
	input wire logic i_detect_valid,
	input wire logic [3:0][23:0] i_detect_sample,
	output logic o_dout,
	output logic o_dout_oe_n,
	output logic o_conversion_ready_n,
	output logic o_ready_oe_n,
	output logic o_channels_off,
	output logic o_modulator_run,
	output logic o_detect_active
);

	acd_state_t st_r;
	acd_state_t st_nxt;
	logic sclk_f;
	logic cs_f;
	logic din_f;
	logic sync_f;
	logic mclk_f;

	acd_pin_sync #(.P_INIT(1'b0)) u_sclk (.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn), .i_pin(i_sclk), .o_level(sclk_f));
	acd_pin_sync #(.P_INIT(1'b1)) u_cs (.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn), .i_pin(i_cs_n), .o_level(cs_f));
	acd_pin_sync #(.P_INIT(1'b0)) u_din (.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn), .i_pin(i_din), .o_level(din_f));
	acd_pin_sync #(.P_INIT(1'b1)) u_sync (.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn), .i_pin(i_sync_reset_n), .o_level(sync_f));
	acd_pin_sync #(.P_INIT(1'b0)) u_mclk (.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn), .i_pin(i_master_clock_input),
		.o_level(mclk_f));

	function automatic logic [5:0] word_bits(input logic [1:0] wl);
		case (wl)
			`ACD_WL_16: word_bits = `ACD_BITS_16;
			`ACD_WL_24: word_bits = `ACD_BITS_24;
			default: word_bits = `ACD_BITS_32;
		endcase
	endfunction

	function automatic logic [11:0] det_len(input logic [2:0] code);
		case (code)
			3'h0: det_len = `ACD_LEN_0;
			3'h1: det_len = `ACD_LEN_1;
			3'h2: det_len = `ACD_LEN_2;
			3'h3: det_len = `ACD_LEN_3;
			3'h4: det_len = `ACD_LEN_4;
			3'h5: det_len = `ACD_LEN_5;
			3'h6: det_len = `ACD_LEN_6;
			default: det_len = `ACD_LEN_7;
		endcase
	endfunction

	// Word 0 answers the previous command; data words follow, MSB first
	function automatic logic [31:0] tx_word(input logic [2:0] idx,
		input logic [15:0] resp, input logic [3:0][23:0] d,
		input logic [1:0] wl);
		logic [23:0] v;
		v = 24'h000000;
		tx_word = 32'h00000000;
		if (idx == 3'h0) begin
			tx_word = {resp, 16'h0000};
		end else if (idx < 3'h5) begin
			v = d[2'(idx - 3'h1)];
			case (wl)
				`ACD_WL_16: tx_word = {v[23:8], 16'h0000};
				`ACD_WL_32S: tx_word = {{8{v[23]}}, v};
				default: tx_word = {v, 8'h00};
			endcase
		end
	endfunction

	always_comb begin
		logic sclk_rise;
		logic sclk_fall;
		logic cs_rise;
		logic cs_fall;
		logic reading;
		logic data_read;
		logic evt;
		logic suppress;
		logic [5:0] wlen;
		logic [31:0] rx_n;
		logic [15:0] resp;
		logic [1:0] lag_i;
		logic [1:0] lead_i;
		logic [1:0] ctl_i;
		logic [9:0] bound;
		logic has_bound;
		logic [3:0] en;
		logic [3:0] met;
		logic [23:0] mag;
		logic [23:0] level;
		logic trigger;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		cs_rise = cs_f && !st_r.cs_q;
		cs_fall = !cs_f && st_r.cs_q;
		data_read = 1'b0;
		evt = 1'b0;
		suppress = 1'b0;
		wlen = word_bits(i_word_length_select);
		rx_n = 32'h00000000;
		resp = 16'h0000;
		lag_i = 2'h0;
		lead_i = 2'h0;
		ctl_i = 2'h0;
		bound = 10'h000;
		has_bound = 1'b1;
		en = i_channel_enable_n;
		met = 4'h0;
		mag = 24'h000000;
		level = {i_detect_level_high_reg, i_detect_level_low_reg};
		trigger = 1'b0;
		st_nxt = st_r;
		st_nxt.sclk_q = sclk_f;
		st_nxt.cs_q = cs_f;
		st_nxt.sync_q = sync_f;
		st_nxt.mclk_q = mclk_f;
		st_nxt.chen_q = en;
		reading = !cs_f && st_r.widx != 3'h0 && st_r.widx < 3'h5;

		if (!cs_f) begin
			sclk_rise = sclk_f && !st_r.sclk_q;
			sclk_fall = !sclk_f && st_r.sclk_q;
		end
		// response to the command of the previous frame
		if (st_r.last_cmd == `ACD_CMD_HOLD ||
			st_r.last_cmd == `ACD_CMD_RESUME) begin
			resp = st_r.last_cmd;
		end else begin
			resp = i_status_word;
		end
		if (cs_fall) begin
			st_nxt.tx = tx_word(3'h0, resp, st_r.data,
				i_word_length_select);
			st_nxt.bitcnt = 6'h00;
			st_nxt.widx = 3'h0;
		end
		if (sclk_rise) begin
			st_nxt.dout = st_r.tx[31];
			st_nxt.tx = {st_r.tx[30:0], 1'b0};
		end
		if (sclk_fall) begin
			rx_n = {st_r.rx[30:0], din_f};
			st_nxt.rx = rx_n;
			st_nxt.bitcnt = st_r.bitcnt + 6'h01;
			if (st_r.bitcnt + 6'h01 == wlen) begin
				st_nxt.bitcnt = 6'h00;
				if (st_r.widx == 3'h0) begin
					st_nxt.cmd = 16'(rx_n >> (wlen - `ACD_BITS_16));
				end
				if (st_r.widx == 3'h4) begin
					data_read = 1'b1;
				end
				if (st_r.widx < `ACD_FRAME_WORDS) begin
					st_nxt.widx = st_r.widx + 3'h1;
				end
				st_nxt.tx = tx_word(st_r.widx + 3'h1, resp,
					st_r.data, i_word_length_select);
			end
		end
		// a frame ends only at chip select rising
		if (cs_rise) begin
			st_nxt.bitcnt = 6'h00;
			st_nxt.widx = 3'h0;
			st_nxt.rx = 32'h00000000;
			st_nxt.last_cmd = st_r.cmd;
			st_nxt.cmd = 16'h0000;
			// hold command powers down, settings untouched
			if (st_r.cmd == `ACD_CMD_HOLD &&
				(st_r.mode == ACD_CONV || st_r.mode == ACD_SETTLE)) begin
				st_nxt.mode = ACD_STBY;
			end
			if (st_r.cmd == `ACD_CMD_RESUME &&
				(st_r.mode == ACD_STBY || st_r.mode == ACD_DETECT)) begin
				st_nxt.mode = ACD_SETTLE;
				st_nxt.settle_cnt = 4'h0;
			end
		end

		// Reset-length measurement of the sync pin low time
		if (!sync_f) begin
			if (st_r.rst_cnt != 16'hFFFF) begin
				st_nxt.rst_cnt = st_r.rst_cnt + 16'h0001;
			end
		end else begin
			st_nxt.rst_cnt = 16'h0000;
		end

		case (st_r.mode)
			ACD_SETTLE: begin
				if (mclk_f && !st_r.mclk_q) begin
					st_nxt.settle_cnt = st_r.settle_cnt + 4'h1;
					if (st_r.settle_cnt == 4'(`ACD_SETTLE_PERIODS - 1)) begin
						st_nxt.mode = ACD_CONV;
						st_nxt.first_pend = 1'b1;
					end
				end
			end
			ACD_STBY: begin
				// short low pulse from standby enters detect
				if (sync_f && !st_r.sync_q && i_detect_enable &&
					st_r.rst_cnt < 16'(P_RESET_LIMIT_CYC)) begin
					st_nxt.mode = ACD_DETECT;
					st_nxt.det_cnt = 12'h000;
					st_nxt.hits = '0;
				end
			end
			ACD_DETECT: begin
				if (!i_detect_enable) begin
					st_nxt.mode = ACD_STBY;
				end else if (i_detect_valid) begin
					// detect samples never reach the data words
					for (int c = 0; c < 4; c++) begin
						mag = i_detect_sample[c][23] ?
							24'(-i_detect_sample[c]) : i_detect_sample[c];
						if (mag > level && st_r.hits[c] != 8'hFF) begin
							st_nxt.hits[c] = st_r.hits[c] + 8'h01;
						end
					end
					st_nxt.det_cnt = st_r.det_cnt + 12'h001;
					// evaluation closes after the selected count
					if (st_r.det_cnt == det_len(i_detect_sample_count) -
						12'h001) begin
						for (int c = 0; c < 4; c++) begin
							met[c] = st_nxt.hits[c] >=
								{5'h00, i_detect_hit_count} + 8'h01;
						end
						if (i_detect_all_channels) begin
							trigger = |en && ((met | ~en) == 4'hF);
						end else begin
							trigger = |(met & en);
						end
						st_nxt.det_cnt = 12'h000;
						st_nxt.hits = '0;
						// notify and fall back to standby
						if (trigger) begin
							st_nxt.rdy_n = 1'b0;
							st_nxt.mode = ACD_STBY;
						end
					end
				end
			end
			default: begin
			end
		endcase

		// Detection notice holds until the host opens a frame
		if (st_r.mode == ACD_STBY && !st_r.rdy_n && cs_fall) begin
			st_nxt.rdy_n = 1'b1;
		end

		// Latest data per channel; overwritten even during a read
		if (st_r.mode == ACD_CONV) begin
			for (int c = 0; c < 4; c++) begin
				if (i_conv_done[c]) begin
					st_nxt.data[c] = i_conv_data[c];
				end
			end
		end

		// lagging is largest phase, leading the smallest
		for (int c = 0; c < 4; c++) begin
			if (en[c] && (!en[lag_i] || $signed(i_channel_phase_trim[c]) >
				$signed(i_channel_phase_trim[lag_i]))) begin
				lag_i = 2'(c);
			end
			if (en[c] && (!en[lead_i] || $signed(i_channel_phase_trim[c]) <
				$signed(i_channel_phase_trim[lead_i]))) begin
				lead_i = 2'(c);
			end
		end
		ctl_i = (i_ready_source_select == `ACD_SEL_LAG) ? lag_i : lead_i;
		if (i_global_chop || i_ready_source_select == `ACD_SEL_ANY) begin
			evt = |(i_conv_done & en);
		end else begin
			evt = i_conv_done[ctl_i] && en[ctl_i];
		end
		if (st_r.mode != ACD_CONV) begin
			evt = 1'b0;
		end

		// restart events re-arm the first-ready check
		if ((st_r.sync_q && !sync_f) || |(en & ~st_r.chen_q)) begin
			st_nxt.first_pend = 1'b1;
		end
		case (i_oversampling_ratio)
			`ACD_OSR_128: bound = `ACD_BOUND_128;
			`ACD_OSR_256: bound = `ACD_BOUND_256;
			`ACD_OSR_512: bound = `ACD_BOUND_512;
			`ACD_OSR_1024: bound = `ACD_BOUND_1024;
			default: has_bound = 1'b0;
		endcase

		if (st_r.gap) begin
			st_nxt.gap = 1'b0;
			st_nxt.rdy_n = 1'b0;
		end
		if (st_r.pulse_cnt != 3'h0) begin
			st_nxt.pulse_cnt = st_r.pulse_cnt - 3'h1;
			if (st_r.pulse_cnt == 3'h1) begin
				st_nxt.rdy_n = 1'b1;
			end
		end
		if (data_read) begin
			st_nxt.unread = 1'b0;
			if (!i_ready_pulse_format && st_r.mode == ACD_CONV) begin
				st_nxt.rdy_n = 1'b1;
			end
		end
		if (evt) begin
			if (st_r.first_pend) begin
				st_nxt.first_pend = 1'b0;
				// at or below boundary waits one more period
				if (has_bound && !i_global_chop && $signed(
					i_channel_phase_trim[ctl_i]) <= $signed(bound)) begin
					suppress = 1'b1;
				end
			end
			// completion during a data read is not flagged
			if (reading) begin
				suppress = 1'b1;
			end
			if (!suppress) begin
				// pulse format, unread result skips one pulse
				if (i_ready_pulse_format) begin
					if (st_r.unread) begin
						st_nxt.unread = 1'b0;
					end else begin
						st_nxt.unread = 1'b1;
						st_nxt.rdy_n = 1'b0;
						st_nxt.pulse_cnt = 3'(`ACD_PULSE_CYC);
					end
				end else if (!st_r.rdy_n) begin
					// brief high before the next low
					st_nxt.rdy_n = 1'b1;
					st_nxt.gap = 1'b1;
					st_nxt.unread = 1'b1;
				end else begin
					st_nxt.rdy_n = 1'b0;
					st_nxt.unread = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= '0;
			st_r.mode <= ACD_CONV;
			st_r.cs_q <= 1'b1;
			st_r.sync_q <= 1'b1;
			st_r.rdy_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// slave output follows the launch flop
	assign o_dout = st_r.dout;
	assign o_dout_oe_n = cs_f;
	assign o_conversion_ready_n = st_r.rdy_n;
	// open drain drives only the low level
	assign o_ready_oe_n = i_ready_open_drain ? st_r.rdy_n : 1'b0;
	assign o_channels_off = st_r.mode != ACD_CONV;
	assign o_modulator_run = st_r.mode == ACD_CONV;
	assign o_detect_active = st_r.mode == ACD_DETECT;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	hold_cmd_a: assert property (
		cs_f && !st_r.cs_q && st_r.cmd == `ACD_CMD_HOLD &&
		st_r.mode == ACD_CONV |=> o_channels_off && !o_modulator_run)
		else $error("hold command did not power down");
	resume_cmd_a: assert property (
		cs_f && !st_r.cs_q && st_r.cmd == `ACD_CMD_RESUME &&
		st_r.mode == ACD_STBY |=> st_r.mode == ACD_SETTLE)
		else $error("resume command did not leave standby");
	settle_wait_a: assert property (
		$rose(o_modulator_run) && $past(st_r.mode) == ACD_SETTLE |->
		$past(st_r.settle_cnt) == 4'h7)
		else $error("sampling restarted before eight periods");
	detect_entry_a: assert property (
		$rose(o_detect_active) |-> $past(st_r.mode) == ACD_STBY &&
		$past(i_detect_enable))
		else $error("detect mode entered from wrong state");
	detect_exit_a: assert property (
		o_detect_active && !st_nxt.rdy_n && st_r.rdy_n |=>
		$fell(o_conversion_ready_n) && st_r.mode == ACD_STBY)
		else $error("detection not flagged with standby return");
	dout_float_a: assert property (
		cs_f && $past(cs_f) |-> o_dout_oe_n && $stable(o_dout) &&
		st_r.bitcnt == 6'h00)
		else $error("output driven while deselected");
	pulse_len_a: assert property (
		$fell(o_conversion_ready_n) && i_ready_pulse_format &&
		o_modulator_run |-> (!o_conversion_ready_n)[*4] ##1
		o_conversion_ready_n)
		else $error("ready pulse width wrong");
	ready_drive_a: assert property (
		i_ready_open_drain && o_conversion_ready_n |-> o_ready_oe_n)
		else $error("open drain output drove high");
	word_len_a: assert property (
		!cs_f |-> st_r.bitcnt < word_bits(i_word_length_select))
		else $error("bit count passed word length");

	detect_hit_c: cover property (o_detect_active ##1
		!o_detect_active && !o_conversion_ready_n);
	hold_resume_c: cover property ($rose(o_channels_off) ##[1:1000]
		$rose(o_modulator_run));
	pulse_c: cover property ($fell(o_conversion_ready_n) &&
		i_ready_pulse_format);

endmodule

// [rtl/acd_params.svh]
// Constants for the converter host port and low-power mode control
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

`define ACD_CLK_PERIOD_NS 25
`define ACD_CMD_HOLD 16'h0022
`define ACD_CMD_RESUME 16'h0033
`define ACD_SETTLE_PERIODS 8
`define ACD_RESET_LIMIT_NS 250000
`define ACD_RESET_LIMIT_CYC (`ACD_RESET_LIMIT_NS / `ACD_CLK_PERIOD_NS)
`define ACD_PULSE_NS 100
`define ACD_PULSE_CYC \
	((`ACD_PULSE_NS + `ACD_CLK_PERIOD_NS - 1) / `ACD_CLK_PERIOD_NS)
`define ACD_FRAME_WORDS 3'h6
`define ACD_WL_16 2'h0
`define ACD_WL_24 2'h1
`define ACD_WL_32Z 2'h2
`define ACD_WL_32S 2'h3
`define ACD_BITS_16 6'h10
`define ACD_BITS_24 6'h18
`define ACD_BITS_32 6'h20
`define ACD_SEL_LAG 2'h0
`define ACD_SEL_ANY 2'h1
`define ACD_OSR_128 3'h0
`define ACD_OSR_256 3'h1
`define ACD_OSR_512 3'h2
`define ACD_OSR_1024 3'h3
`define ACD_BOUND_128 10'h3ED
`define ACD_BOUND_256 10'h3AD
`define ACD_BOUND_512 10'h32D
`define ACD_BOUND_1024 10'h22D
`define ACD_LEN_0 12'h080
`define ACD_LEN_1 12'h100
`define ACD_LEN_2 12'h200
`define ACD_LEN_3 12'h300
`define ACD_LEN_4 12'h400
`define ACD_LEN_5 12'h600
`define ACD_LEN_6 12'h800
`define ACD_LEN_7 12'hE00

`endif

// [rtl/acd_pkg.sv]
// Types shared by the converter host port design files
package acd_pkg;

	typedef enum logic [1:0] {
		ACD_CONV = 2'b00,
		ACD_STBY = 2'b01,
		ACD_SETTLE = 2'b10,
		ACD_DETECT = 2'b11
	} acd_mode_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} acd_sync_t;

	typedef struct packed {
		acd_mode_t mode;
		logic [3:0] settle_cnt;
		logic sclk_q;
		logic cs_q;
		logic sync_q;
		logic mclk_q;
		logic [3:0] chen_q;
		logic [31:0] tx;
		logic [31:0] rx;
		logic [5:0] bitcnt;
		logic [2:0] widx;
		logic [15:0] cmd;
		logic [15:0] last_cmd;
		logic dout;
		logic [3:0][23:0] data;
		logic rdy_n;
		logic gap;
		logic unread;
		logic [2:0] pulse_cnt;
		logic first_pend;
		logic [15:0] rst_cnt;
		logic [11:0] det_cnt;
		logic [3:0][7:0] hits;
	} acd_state_t;

endpackage

// [rtl/acd_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module acd_pin_sync
	import acd_pkg::*;
#(
	parameter logic P_INIT = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_pin,
	output logic o_level
);

	acd_sync_t st_r;
	acd_sync_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = i_pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// Only a level seen by both late stages is accepted
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= '{s1: P_INIT, s2: P_INIT, s3: P_INIT, q: P_INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_level = st_r.q;

endmodule

// [verification/acd_spi_host.sv]
// Host serial master model driving whole command frames
`timescale 1ns/10ps
module acd_spi_host (
	input wire logic i_ref_clk,
	input wire logic i_dout,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din
);
	// Half serial period in ref clocks, well above the pin filter delay
	localparam int HALF = 8;

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end

	task automatic xfer(input logic [15:0] cmd, input int bits,
		output logic [191:0] rx);
		logic [191:0] tx;
		tx = {cmd, 176'h0};
		rx = '0;
		@(posedge i_ref_clk);
		o_cs_n <= 1'b0;
		repeat (HALF) @(posedge i_ref_clk);
		for (int i = 0; i < bits * 6; i++) begin
			o_sclk <= 1'b1;
			o_din <= tx[191 - i];
			repeat (HALF) @(posedge i_ref_clk);
			rx[191 - i] = i_dout;
			o_sclk <= 1'b0;
			repeat (HALF) @(posedge i_ref_clk);
		end
		o_cs_n <= 1'b1;
		// Released line must not keep showing the last bit
		o_din <= ~o_din;
		repeat (HALF) @(posedge i_ref_clk);
	endtask
endmodule

// [verification/adc_host_port_and_low_power_modes_tb.sv]
// Self-checking bench for the converter host port and power modes
`timescale 1ns/10ps
`include "acd_params.svh"
module adc_host_port_and_low_power_modes_tb;
	logic i_ref_clk, i_rstn, i_sclk, i_cs_n, i_din, i_sync_reset_n;
	logic i_master_clock_input, i_ready_open_drain, i_ready_pulse_format;
	logic i_global_chop, i_detect_enable, i_detect_all_channels;
	logic i_detect_valid;
	logic [1:0] i_word_length_select, i_ready_source_select;
	logic [2:0] i_oversampling_ratio, i_detect_sample_count;
	logic [2:0] i_detect_hit_count;
	logic [3:0] i_channel_enable_n, i_conv_done;
	logic [3:0][9:0] i_channel_phase_trim;
	logic [15:0] i_status_word, i_detect_level_high_reg;
	logic [7:0] i_detect_level_low_reg;
	logic [3:0][23:0] i_conv_data, i_detect_sample, dexp;
	logic o_dout, o_dout_oe_n, o_conversion_ready_n, o_ready_oe_n;
	logic o_channels_off, o_modulator_run, o_detect_active;
	wire logic dout_pin;
	logic [191:0] rx;
	logic [23:0] lvl;
	int num_errors, check_count, lowc, b;
	// Source select, event mask, ready expected
	logic [6:0] sel_tbl [5] = '{7'h02, 7'h09, 7'h23, 7'h48, 7'h65};

	assign dout_pin = o_dout_oe_n ? 1'bz : o_dout;

	acd_host_port #(.P_RESET_LIMIT_CYC(64)) u_acd_host_port (
		.i_ref_clk, .i_rstn, .i_sclk, .i_cs_n, .i_din, .i_sync_reset_n,
		.i_master_clock_input, .i_word_length_select,
		.i_ready_source_select, .i_ready_open_drain, .i_ready_pulse_format,
		.i_global_chop, .i_oversampling_ratio, .i_channel_enable_n,
		.i_channel_phase_trim, .i_status_word, .i_conv_done, .i_conv_data,
		.i_detect_enable, .i_detect_level_high_reg, .i_detect_level_low_reg,
		.i_detect_sample_count, .i_detect_hit_count,
		.i_detect_all_channels, .i_detect_valid, .i_detect_sample,
		.o_dout, .o_dout_oe_n, .o_conversion_ready_n, .o_ready_oe_n,
		.o_channels_off, .o_modulator_run, .o_detect_active
	);

	acd_spi_host u_acd_spi_host (
		.i_ref_clk, .i_dout(dout_pin), .o_sclk(i_sclk), .o_cs_n(i_cs_n),
		.o_din(i_din)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	task automatic check(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic conclude;
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask

	function automatic int bw(input logic [1:0] w);
		return (w == `ACD_WL_16) ? 16 : (w == `ACD_WL_24) ? 24 : 32;
	endfunction

	function automatic logic [31:0] fmt(input logic [23:0] d,
		input logic [1:0] w);
		case (w)
			`ACD_WL_16: return {16'h0000, d[23:8]};
			`ACD_WL_24: return {8'h00, d};
			`ACD_WL_32Z: return {d, 8'h00};
			default: return {{8{d[23]}}, d};
		endcase
	endfunction

	function automatic logic [31:0] wd(input logic [191:0] r, input int k,
		input int n);
		logic [191:0] t;
		t = r << (k * n);
		return t[191:160] >> (32 - n);
	endfunction

	task automatic sync_pulse;
		@(posedge i_ref_clk);
		i_sync_reset_n <= 1'b0;
		repeat (10) @(posedge i_ref_clk);
		i_sync_reset_n <= 1'b1;
		tick(8);
	endtask

	task automatic mclk(input int n);
		repeat (n) begin
			@(posedge i_ref_clk);
			i_master_clock_input <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			i_master_clock_input <= 1'b0;
			repeat (4) @(posedge i_ref_clk);
		end
		tick(6);
	endtask

	// Conversion event on masked channels, level format reads it back
	task automatic ev(input logic [3:0] m, input logic e);
		logic [23:0] v;
		lowc = 0;
		@(posedge i_ref_clk);
		for (int c = 0; c < 4; c++) begin
			v = 24'($urandom);
			if (m[c])
				dexp[c] = v;
		end
		i_conv_done <= m;
		i_conv_data <= dexp;
		i_ready_open_drain <= 1'($urandom);
		@(posedge i_ref_clk);
		i_conv_done <= 4'h0;
		repeat (10) begin
			@(negedge i_ref_clk);
			lowc += int'(o_conversion_ready_n === 1'b0);
		end
		check(o_ready_oe_n,
			i_ready_open_drain & (i_ready_pulse_format | !e));
		if (!i_ready_pulse_format) begin
			check(lowc != 0, e);
			if (lowc != 0) begin
				u_acd_spi_host.xfer(16'h0000, bw(i_word_length_select), rx);
				check(o_conversion_ready_n, 1'b1);
			end
		end
	endtask

	// Detect samples: two or one exceeding hits per channel, rest at level
	task automatic deval(input logic [3:0] two, input logic [3:0] one);
		for (int i = 0; i < int'(`ACD_LEN_0); i++) begin
			@(posedge i_ref_clk);
			for (int c = 0; c < 4; c++)
				i_detect_sample[c] <= (i < (two[c] ? 2 : one[c] ? 1 : 0)) ?
					(i[0] ? lvl + 24'h1 : -(lvl + 24'h1)) : lvl;
			i_detect_valid <= 1'b1;
			@(posedge i_ref_clk);
			i_detect_valid <= 1'b0;
		end
		tick(4);
	endtask

	initial begin
		repeat (90000) @(posedge i_ref_clk);
		num_errors++;
		conclude;
	end

	initial begin
		void'($urandom(32'h22D9));
		i_rstn = 1'b0;
		i_sync_reset_n = 1'b1;
		i_master_clock_input = 1'b0;
		i_ready_open_drain = 1'b0;
		i_ready_pulse_format = 1'b0;
		i_global_chop = 1'b0;
		i_detect_enable = 1'b0;
		i_detect_all_channels = 1'b0;
		i_detect_valid = 1'b0;
		i_word_length_select = `ACD_WL_24;
		i_ready_source_select = `ACD_SEL_ANY;
		i_oversampling_ratio = `ACD_OSR_128;
		i_detect_sample_count = 3'h0;
		i_detect_hit_count = 3'h1;
		i_channel_enable_n = 4'hF;
		i_conv_done = 4'h0;
		i_channel_phase_trim = '0;
		i_status_word = 16'($urandom);
		lvl = 24'($urandom) & 24'h3FFFFF;
		i_detect_level_high_reg = lvl[23:8];
		i_detect_level_low_reg = lvl[7:0];
		i_conv_data = '0;
		i_detect_sample = '0;
		dexp = '0;
		repeat (4) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		tick(2);
		check(o_dout_oe_n, 1'b1);
		check(o_ready_oe_n, 1'b0);
		check({o_modulator_run, o_channels_off, o_detect_active}, 3'h4);
		u_acd_spi_host.xfer(16'h0000, 24, rx);
		check(o_dout_oe_n, 1'b1);
		for (int w = 0; w < 4; w++) begin
			@(posedge i_ref_clk);
			i_word_length_select <= w[1:0];
			ev(4'hF, 1'b1);
			b = bw(w[1:0]);
			check(wd(rx, 0, b), 32'(i_status_word) << (b - 16));
			for (int k = 1; k < 5; k++)
				check(wd(rx, k, b), fmt(dexp[k - 1], w[1:0]));
		end
		i_channel_phase_trim <= {10'h000, 10'h005, 10'h3FB, 10'h000};
		i_word_length_select <= `ACD_WL_16;
		foreach (sel_tbl[t]) begin
			@(posedge i_ref_clk);
			i_ready_source_select <= sel_tbl[t][6:5];
			ev(sel_tbl[t][4:1], sel_tbl[t][0]);
		end
		i_channel_phase_trim <= {20'h0, `ACD_BOUND_128, 10'h000};
		sync_pulse;
		check(o_detect_active, 1'b0);
		ev(4'h2, 1'b0);
		ev(4'h2, 1'b1);
		i_channel_phase_trim <= {20'h0, `ACD_BOUND_128 + 10'h001, 10'h000};
		sync_pulse;
		ev(4'h2, 1'b1);
		// global chop ignores the source select
		@(posedge i_ref_clk);
		i_global_chop <= 1'b1;
		ev(4'h1, 1'b1);
		@(posedge i_ref_clk);
		i_global_chop <= 1'b0;
		i_channel_phase_trim <= {20'h0, 10'h200, 10'h000};
		// widest ratio boundary, then no boundary at all
		for (int r = 3; r < 5; r++) begin
			@(posedge i_ref_clk);
			i_oversampling_ratio <= 3'(r);
			sync_pulse;
			ev(4'h2, 1'(r == 4));
			ev(4'h2, 1'b1);
		end
		fork
			u_acd_spi_host.xfer(16'h0000, 16, rx);
			begin
				repeat (400) @(posedge i_ref_clk);
				i_conv_done <= 4'h2;
				@(posedge i_ref_clk);
				i_conv_done <= 4'h0;
				tick(6);
				check(o_conversion_ready_n, 1'b1);
			end
		join
		i_ready_source_select <= `ACD_SEL_ANY;
		i_ready_pulse_format <= 1'b1;
		for (int j = 0; j < 3; j++) begin
			ev(4'h1, 1'b1);
			check(lowc, (j == 1) ? 0 : `ACD_PULSE_CYC);
		end
		@(posedge i_ref_clk);
		i_ready_pulse_format <= 1'b0;
		u_acd_spi_host.xfer(`ACD_CMD_HOLD, 16, rx);
		tick(8);
		check({o_modulator_run, o_channels_off}, 2'h1);
		@(posedge i_ref_clk);
		i_channel_enable_n <= 4'h7;
		sync_pulse;
		check(o_detect_active, 1'b0);
		@(posedge i_ref_clk);
		i_detect_enable <= 1'b1;
		sync_pulse;
		check(o_detect_active, 1'b1);
		deval(4'h8, 4'h7);
		check({o_detect_active, o_conversion_ready_n}, 2'h3);
		@(posedge i_ref_clk);
		i_detect_all_channels <= 1'b1;
		deval(4'h3, 4'h4);
		check({o_detect_active, o_conversion_ready_n}, 2'h3);
		deval(4'h7, 4'h0);
		check({o_detect_active, o_conversion_ready_n, o_channels_off},
			3'h1);
		u_acd_spi_host.xfer(`ACD_CMD_RESUME, 16, rx);
		check(o_conversion_ready_n, 1'b1);
		check(wd(rx, 0, 16), 32'(`ACD_CMD_HOLD));
		mclk(`ACD_SETTLE_PERIODS - 1);
		check(o_modulator_run, 1'b0);
		mclk(1);
		check({o_modulator_run, o_channels_off}, 2'h2);
		ev(4'h1, 1'b1);
		conclude;
	end
endmodule
